// *** hw/rip_pkg.sv ***
// Functional notes
// - terminal time tag counter has its own counter, internal or external clock.
// - monitor time tag counter picks its own clock source independently.
// - master reset pin low resets the block; status register write requests soft resets.
// - each bus inhibit pin ORed with its configuration bit blocks that bus.
// - after master reset release, run RAM test unless the test-disable input is high.
// - self-init enable high at reset release copies EEPROM data into the configuration register and RAM.
// - self-init loads 0x0..0x1FFF, or only 0x0..0x07FF when short range is high.
// - short range input is ignored when self-init was disabled at reset.
// - ready stays low during self-init or RAM test, rises when both finish.
// - while not ready, host writes blocked and every read returns status register.
// - activity output high while the terminal processes a message.
// - monitor-activity-include bit 1 ORs monitor activity onto the activity output.
// - block is controller on a four-wire EEPROM port: select, clock, out, in.
// - terminal address and parity pins latched at master reset release.
package rip_pkg;
   localparam int ADDR_W = 13;
   localparam int DATA_W = 16;
   localparam logic [12:0] REG_CFG_ADDR = 13'h0000;
   localparam logic [12:0] REG_STATUS_ADDR = 13'h0001;
   localparam logic [15:0] CFG_RESET = 16'h0000;
   localparam int CFG_MON_ACT_BIT = 1;
   localparam int CFG_INH_A_BIT = 4;
   localparam int CFG_INH_B_BIT = 5;
   localparam int CFG_RT_EXT_BIT = 6;
   localparam int CFG_MT_EXT_BIT = 7;
   localparam int ST_RT_SRST_BIT = 0;
   localparam int ST_MT_SRST_BIT = 1;
   localparam int ST_SELF_EN_BIT = 11;
   localparam int ST_SHORT_BIT = 12;
   localparam int ST_TEST_BIT = 13;
   localparam int ST_INIT_BIT = 14;
   localparam int ST_READY_BIT = 15;
   localparam logic [12:0] INIT_LAST_FULL = 13'h1FFF;
   localparam logic [12:0] INIT_LAST_SHORT = 13'h07FF;
   localparam logic [7:0] EE_READ_CMD = 8'h03;
   localparam logic [15:0] EE_START_ADDR = 16'h0000;
   localparam logic [4:0] EE_HDR_LAST = 5'h17;
   localparam logic [4:0] EE_WORD_LAST = 5'h0F;
   localparam int CLK_NS = 50;
   localparam int SCK_HALF_NS = 200;
   localparam int SCK_HALF_CYC = (SCK_HALF_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [3:0] SCK_TICK = 4'(SCK_HALF_CYC - 1);
   localparam int TT_INT_NS = 1000;
   localparam int TT_INT_CYC = (TT_INT_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [4:0] TT_TICK = 5'(TT_INT_CYC - 1);
   localparam int BUF_W = ADDR_W + DATA_W;
   localparam logic [1:0] BUF_DEPTH = 2'h2;
   localparam int PIN_N = 15;
   localparam int PIN_MR = 0;
   localparam int PIN_RT_CLK = 1;
   localparam int PIN_MT_CLK = 2;
   localparam int PIN_INH_A = 3;
   localparam int PIN_INH_B = 4;
   localparam int PIN_TEST_DIS = 5;
   localparam int PIN_SELF_EN = 6;
   localparam int PIN_SHORT = 7;
   localparam int PIN_MISO = 8;
   localparam int PIN_ADDR_LO = 9;
   localparam int PIN_PARITY = 14;
   typedef enum logic [2:0] {
      SEQ_HOLD = 3'h0,
      SEQ_TEST = 3'h1,
      SEQ_INIT = 3'h3,
      SEQ_DRAIN = 3'h2,
      SEQ_RUN = 3'h6
   } rip_seq_e;
   typedef enum logic [1:0] {
      SPI_IDLE = 2'h0,
      SPI_HDR = 2'h1,
      SPI_DATA = 2'h3,
      SPI_END = 2'h2
   } rip_spi_e;
endpackage

// *** hw/rip_buf2.sv ***
`timescale 1ns/1ps
module rip_buf2
   import rip_pkg::*;
#(
   parameter int W = 8
)
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   logic [W-1:0] slot0_q;
   logic [W-1:0] slot1_q;
   logic [1:0] cnt_q;
   logic [1:0] cnt_d;
   logic in_ready_q;
   logic out_valid_q;
   logic push;
   logic pop;

   assign push = in_valid & in_ready_q;
   assign pop = out_valid_q & out_ready;
   assign in_ready = in_ready_q;
   assign out_valid = out_valid_q;
   assign out_data = slot0_q;

   always_comb
   begin
      cnt_d = cnt_q;
      if (push && !pop)
      begin
         cnt_d = cnt_q + 2'h1;
      end
      else if (pop && !push)
      begin
         cnt_d = cnt_q - 2'h1;
      end
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         cnt_q <= 2'h0;
         in_ready_q <= 1'b0;
         out_valid_q <= 1'b0;
      end
      else
      begin
         cnt_q <= cnt_d;
         in_ready_q <= (cnt_d != BUF_DEPTH);
         out_valid_q <= (cnt_d != 2'h0);
      end
   end

   always_ff @(posedge clk)
   begin
      if (pop)
      begin
         slot0_q <= (cnt_q == 2'h1) ? in_data : slot1_q;
      end
      else if (push && cnt_q == 2'h0)
      begin
         slot0_q <= in_data;
      end
      if (push && !(pop && cnt_q == 2'h1))
      begin
         slot1_q <= in_data;
      end
   end
endmodule

// *** hw/rip_top.sv ***
`timescale 1ns/1ps
module rip_top
   import rip_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic master_reset_n,
   input wire logic rt_timetag_clock_in,
   input wire logic monitor_timetag_clock_in,
   input wire logic bus_a_transmit_inhibit,
   input wire logic bus_b_transmit_inhibit,
   input wire logic ram_test_disable,
   input wire logic self_init_enable,
   input wire logic self_init_short_range,
   input wire logic [4:0] terminal_address_pins,
   input wire logic terminal_address_parity_pin,
   input wire logic eeprom_miso,
   output logic eeprom_chip_select_n,
   output logic eeprom_serial_clock,
   output logic eeprom_mosi,
   input wire logic rt_busy,
   input wire logic mt_busy,
   output logic ram_test_req,
   input wire logic ram_test_done,
   input wire logic host_wr_en,
   input wire logic host_rd_en,
   input wire logic [12:0] host_addr,
   input wire logic [15:0] host_wr_data,
   output logic [15:0] host_rd_data,
   output logic host_rd_valid,
   output logic mem_wr_en,
   output logic [12:0] mem_wr_addr,
   output logic [15:0] mem_wr_data,
   input wire logic mem_wr_ready,
   input wire logic [15:0] mem_rd_data,
   output logic ready,
   output logic activity,
   output logic bus_a_tx_block,
   output logic bus_b_tx_block,
   output logic rt_soft_reset,
   output logic mt_soft_reset,
   output logic [15:0] rt_time_tag,
   output logic [15:0] mt_time_tag,
   output logic [4:0] terminal_address,
   output logic terminal_address_parity
);
   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] pin_meta_q;
   logic [PIN_N-1:0] pin_sync_q;
   logic mr_prev_q;
   logic mr_rise;
   logic core_rst;
   logic strap_en_q;
   logic strap_short_q;
   logic [4:0] term_addr_q;
   logic term_par_q;
   rip_seq_e seq_q;
   rip_spi_e spi_q;
   logic ready_q;
   logic test_req_q;
   logic [3:0] div_q;
   logic [4:0] bit_q;
   logic [23:0] tx_q;
   logic [15:0] rx_q;
   logic [12:0] word_addr_q;
   logic push_q;
   logic sck_q;
   logic cs_n_q;
   logic mosi_q;
   logic [12:0] last_addr;
   logic stall;
   logic buf_in_ready;
   logic buf_out_valid;
   logic [BUF_W-1:0] buf_out_data;
   logic mem_free;
   logic buf_take;
   logic [12:0] buf_addr;
   logic [15:0] buf_data;
   logic host_wr_ok;
   logic mem_wr_en_q;
   logic [12:0] mem_wr_addr_q;
   logic [15:0] mem_wr_data_q;
   logic [15:0] cfg_q;
   logic [15:0] status_w;
   logic [15:0] rd_data_q;
   logic rd_valid_q;
   logic rt_srst_q;
   logic mt_srst_q;
   logic blk_a_q;
   logic blk_b_q;
   logic act_q;
   logic [4:0] tt_div_q;
   logic int_tick;
   logic rt_clk_prev_q;
   logic mt_clk_prev_q;
   logic rt_tick;
   logic mt_tick;
   logic [15:0] rt_tt_q;
   logic [15:0] mt_tt_q;

   assign pin_raw = {terminal_address_parity_pin, terminal_address_pins, eeprom_miso,
                     self_init_short_range, self_init_enable, ram_test_disable,
                     bus_b_transmit_inhibit, bus_a_transmit_inhibit,
                     monitor_timetag_clock_in, rt_timetag_clock_in, master_reset_n};

   // every pin is foreign to clk; only the second stage is read
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         pin_meta_q <= '0;
         pin_sync_q <= '0;
      end
      else
      begin
         pin_meta_q <= pin_raw;
         pin_sync_q <= pin_meta_q;
      end
   end

   // prev starts low so a pin already high at power-up counts as a release
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         mr_prev_q <= 1'b0;
      end
      else
      begin
         mr_prev_q <= pin_sync_q[PIN_MR];
      end
   end

   assign mr_rise = pin_sync_q[PIN_MR] & ~mr_prev_q;
   assign core_rst = ~reset_n | ~pin_sync_q[PIN_MR];

   // straps taken on the release edge, pins ignored afterwards
   always_ff @(posedge clk)
   begin
      if (!reset_n)
      begin
         strap_en_q <= 1'b0;
         strap_short_q <= 1'b0;
         term_addr_q <= 5'h00;
         term_par_q <= 1'b0;
      end
      else if (mr_rise)
      begin
         strap_en_q <= pin_sync_q[PIN_SELF_EN];
         strap_short_q <= pin_sync_q[PIN_SELF_EN] & pin_sync_q[PIN_SHORT];
         term_addr_q <= pin_sync_q[PIN_ADDR_LO +: 5];
         term_par_q <= pin_sync_q[PIN_PARITY];
      end
   end

   always_ff @(posedge clk)
   begin
      if (core_rst)
      begin
         seq_q <= SEQ_HOLD;
      end
      else
      begin
         case (seq_q)
            SEQ_HOLD:
            begin
               if (mr_rise)
               begin
                  if (!pin_sync_q[PIN_TEST_DIS])
                  begin
                     seq_q <= SEQ_TEST;
                  end
                  else if (pin_sync_q[PIN_SELF_EN])
                  begin
                     seq_q <= SEQ_INIT;
                  end
                  else
                  begin
                     seq_q <= SEQ_RUN;
                  end
               end
            end
            SEQ_TEST:
            begin
               if (ram_test_done)
               begin
                  seq_q <= strap_en_q ? SEQ_INIT : SEQ_RUN;
               end
            end
            SEQ_INIT:
            begin
               if (spi_q == SPI_END && !push_q)
               begin
                  seq_q <= SEQ_DRAIN;
               end
            end
            SEQ_DRAIN:
            begin
               // last word must reach memory before ready rises
               if (!buf_out_valid && !mem_wr_en_q)
               begin
                  seq_q <= SEQ_RUN;
               end
            end
            SEQ_RUN:
            begin
               seq_q <= SEQ_RUN;
            end
            default:
            begin
               seq_q <= SEQ_HOLD;
            end
         endcase
      end
   end

   always_ff @(posedge clk)
   begin
      if (core_rst)
      begin
         ready_q <= 1'b0;
         test_req_q <= 1'b0;
      end
      else
      begin
         ready_q <= (seq_q == SEQ_RUN);
         test_req_q <= (seq_q == SEQ_TEST) & ~ram_test_done;
      end
   end

   assign last_addr = strap_short_q ? INIT_LAST_SHORT : INIT_LAST_FULL;
   // eeprom clock halts while a finished word waits for buffer room
   assign stall = push_q & ~buf_in_ready;

   always_ff @(posedge clk)
   begin
      if (core_rst)
      begin
         spi_q <= SPI_IDLE;
         cs_n_q <= 1'b1;
         sck_q <= 1'b0;
         mosi_q <= 1'b0;
         div_q <= 4'h0;
         bit_q <= 5'h00;
         tx_q <= 24'h000000;
         rx_q <= 16'h0000;
         word_addr_q <= 13'h0000;
         push_q <= 1'b0;
      end
      else
      begin
         if (push_q && buf_in_ready)
         begin
            push_q <= 1'b0;
            word_addr_q <= word_addr_q + 13'h0001;
         end
         case (spi_q)
            SPI_IDLE:
            begin
               if (seq_q == SEQ_INIT)
               begin
                  spi_q <= SPI_HDR;
                  cs_n_q <= 1'b0;
                  tx_q <= {EE_READ_CMD, EE_START_ADDR};
                  mosi_q <= EE_READ_CMD[7];
                  bit_q <= EE_HDR_LAST;
                  div_q <= 4'h0;
               end
            end
            SPI_HDR, SPI_DATA:
            begin
               if (!stall)
               begin
                  div_q <= (div_q == SCK_TICK) ? 4'h0 : div_q + 4'h1;
                  if (div_q == SCK_TICK)
                  begin
                     sck_q <= ~sck_q;
                     // falling edge: shift out next bit, take the settled input bit
                     if (sck_q && spi_q == SPI_HDR)
                     begin
                        if (bit_q == 5'h00)
                        begin
                           spi_q <= SPI_DATA;
                           bit_q <= EE_WORD_LAST;
                           mosi_q <= 1'b0;
                        end
                        else
                        begin
                           bit_q <= bit_q - 5'h01;
                           tx_q <= {tx_q[22:0], 1'b0};
                           mosi_q <= tx_q[22];
                        end
                     end
                     else if (sck_q)
                     begin
                        rx_q <= {rx_q[14:0], pin_sync_q[PIN_MISO]};
                        if (bit_q == 5'h00)
                        begin
                           push_q <= 1'b1;
                           bit_q <= EE_WORD_LAST;
                           if (word_addr_q == last_addr)
                           begin
                              spi_q <= SPI_END;
                           end
                        end
                        else
                        begin
                           bit_q <= bit_q - 5'h01;
                        end
                     end
                  end
               end
            end
            SPI_END:
            begin
               if (!push_q)
               begin
                  cs_n_q <= 1'b1;
               end
            end
            default:
            begin
               spi_q <= SPI_IDLE;
            end
         endcase
      end
   end

   rip_buf2 #(
      .W(BUF_W)
   ) u_buf (
      .clk(clk),
      .rst_n(~core_rst),
      .in_valid(push_q),
      .in_data({word_addr_q, rx_q}),
      .in_ready(buf_in_ready),
      .out_valid(buf_out_valid),
      .out_data(buf_out_data),
      .out_ready(mem_free)
   );

   assign mem_free = ~mem_wr_en_q | mem_wr_ready;
   assign buf_take = buf_out_valid & mem_free;
   assign buf_addr = buf_out_data[BUF_W-1:DATA_W];
   assign buf_data = buf_out_data[DATA_W-1:0];
   assign host_wr_ok = host_wr_en & ready_q;

   always_ff @(posedge clk)
   begin
      if (core_rst)
      begin
         mem_wr_en_q <= 1'b0;
         mem_wr_addr_q <= 13'h0000;
         mem_wr_data_q <= 16'h0000;
      end
      else
      begin
         if (mem_wr_en_q && mem_wr_ready)
         begin
            mem_wr_en_q <= 1'b0;
         end
         if (buf_take && buf_addr > REG_STATUS_ADDR)
         begin
            mem_wr_en_q <= 1'b1;
            mem_wr_addr_q <= buf_addr;
            mem_wr_data_q <= buf_data;
         end
         else if (host_wr_ok && host_addr > REG_STATUS_ADDR)
         begin
            mem_wr_en_q <= 1'b1;
            mem_wr_addr_q <= host_addr;
            mem_wr_data_q <= host_wr_data;
         end
      end
   end

   // status word is never loaded from the eeprom image
   always_ff @(posedge clk)
   begin
      if (core_rst)
      begin
         cfg_q <= CFG_RESET;
      end
      else if (buf_take && buf_addr == REG_CFG_ADDR)
      begin
         cfg_q <= buf_data;
      end
      else if (host_wr_ok && host_addr == REG_CFG_ADDR)
      begin
         cfg_q <= host_wr_data;
      end
   end

   always_ff @(posedge clk)
   begin
      if (core_rst)
      begin
         rt_srst_q <= 1'b0;
         mt_srst_q <= 1'b0;
      end
      else
      begin
         rt_srst_q <= host_wr_ok & (host_addr == REG_STATUS_ADDR)
                      & host_wr_data[ST_RT_SRST_BIT];
         mt_srst_q <= host_wr_ok & (host_addr == REG_STATUS_ADDR)
                      & host_wr_data[ST_MT_SRST_BIT];
      end
   end

   always_comb
   begin
      status_w = 16'h0000;
      status_w[ST_RT_SRST_BIT] = rt_srst_q;
      status_w[ST_MT_SRST_BIT] = mt_srst_q;
      status_w[ST_SELF_EN_BIT] = strap_en_q;
      status_w[ST_SHORT_BIT] = strap_short_q;
      status_w[ST_TEST_BIT] = (seq_q == SEQ_TEST);
      status_w[ST_INIT_BIT] = (seq_q == SEQ_INIT) | (seq_q == SEQ_DRAIN);
      status_w[ST_READY_BIT] = ready_q;
   end

   always_ff @(posedge clk)
   begin
      if (core_rst)
      begin
         rd_valid_q <= 1'b0;
         rd_data_q <= 16'h0000;
      end
      else
      begin
         rd_valid_q <= host_rd_en;
         if (host_rd_en)
         begin
            if (!ready_q || host_addr == REG_STATUS_ADDR)
            begin
               rd_data_q <= status_w;
            end
            else if (host_addr == REG_CFG_ADDR)
            begin
               rd_data_q <= cfg_q;
            end
            else
            begin
               rd_data_q <= mem_rd_data;
            end
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (core_rst)
      begin
         blk_a_q <= 1'b0;
         blk_b_q <= 1'b0;
         act_q <= 1'b0;
      end
      else
      begin
         blk_a_q <= pin_sync_q[PIN_INH_A] | cfg_q[CFG_INH_A_BIT];
         blk_b_q <= pin_sync_q[PIN_INH_B] | cfg_q[CFG_INH_B_BIT];
         act_q <= rt_busy | (cfg_q[CFG_MON_ACT_BIT] & mt_busy);
      end
   end

   // one shared prescaler feeds both internal time bases
   always_ff @(posedge clk)
   begin
      if (core_rst)
      begin
         tt_div_q <= 5'h00;
         rt_clk_prev_q <= 1'b0;
         mt_clk_prev_q <= 1'b0;
      end
      else
      begin
         tt_div_q <= (tt_div_q == TT_TICK) ? 5'h00 : tt_div_q + 5'h01;
         rt_clk_prev_q <= pin_sync_q[PIN_RT_CLK];
         mt_clk_prev_q <= pin_sync_q[PIN_MT_CLK];
      end
   end

   assign int_tick = (tt_div_q == TT_TICK);
   assign rt_tick = cfg_q[CFG_RT_EXT_BIT] ?
                    (pin_sync_q[PIN_RT_CLK] & ~rt_clk_prev_q) : int_tick;
   assign mt_tick = cfg_q[CFG_MT_EXT_BIT] ?
                    (pin_sync_q[PIN_MT_CLK] & ~mt_clk_prev_q) : int_tick;

   always_ff @(posedge clk)
   begin
      if (core_rst || rt_srst_q)
      begin
         rt_tt_q <= 16'h0000;
      end
      else if (rt_tick)
      begin
         rt_tt_q <= rt_tt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (core_rst || mt_srst_q)
      begin
         mt_tt_q <= 16'h0000;
      end
      else if (mt_tick)
      begin
         mt_tt_q <= mt_tt_q + 16'h0001;
      end
   end

   assign eeprom_chip_select_n = cs_n_q;
   assign eeprom_serial_clock = sck_q;
   assign eeprom_mosi = mosi_q;
   assign ram_test_req = test_req_q;
   assign host_rd_data = rd_data_q;
   assign host_rd_valid = rd_valid_q;
   assign mem_wr_en = mem_wr_en_q;
   assign mem_wr_addr = mem_wr_addr_q;
   assign mem_wr_data = mem_wr_data_q;
   assign ready = ready_q;
   assign activity = act_q;
   assign bus_a_tx_block = blk_a_q;
   assign bus_b_tx_block = blk_b_q;
   assign rt_soft_reset = rt_srst_q;
   assign mt_soft_reset = mt_srst_q;
   assign rt_time_tag = rt_tt_q;
   assign mt_time_tag = mt_tt_q;
   assign terminal_address = term_addr_q;
   assign terminal_address_parity = term_par_q;
endmodule

// *** dv/rip_eeprom.sv ***
`timescale 1ns/1ps
module rip_eeprom (
   input wire logic cs_n,
   input wire logic sck,
   input wire logic mosi,
   output logic miso
);
   int bit_cnt;
   int d;
   logic [23:0] hdr_q;
   initial miso = 1'b0;
   always @(negedge cs_n) bit_cnt = 0;
   always @(posedge sck)
      if (!cs_n)
      begin
         bit_cnt <= bit_cnt + 1;
         if (bit_cnt < 24)
            hdr_q <= {hdr_q[22:0], mosi};
      end
   // word k is a pattern of k; line pulled down while deselected
   always @(negedge sck or posedge cs_n)
   begin
      d = bit_cnt - 24;
      miso <= !cs_n && d >= 0 && 1'(16'(d / 16 * 16'h0107 + 16'h3C5A) >> (15 - d % 16));
   end
endmodule

// *** dv/rip_top_chk.sv ***
`timescale 1ns/1ps
module rip_top_chk
   import rip_pkg::*;
(
   input wire logic clk,
   input wire logic reset_n,
   input wire logic master_reset_n,
   input wire logic bus_a_transmit_inhibit,
   input wire logic host_rd_en,
   input wire logic ram_test_done,
   input wire logic mem_wr_ready,
   input wire logic eeprom_chip_select_n,
   input wire logic eeprom_serial_clock,
   input wire logic ram_test_req,
   input wire logic host_rd_valid,
   input wire logic [15:0] host_rd_data,
   input wire logic mem_wr_en,
   input wire logic [12:0] mem_wr_addr,
   input wire logic [15:0] mem_wr_data,
   input wire logic ready,
   input wire logic bus_a_tx_block
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   reset_ready_a: assert property (!master_reset_n [*4] |-> !ready)
      else $error("ready in reset");
   blocked_read_a: assert property (host_rd_en && !ready |=>
      host_rd_valid && !host_rd_data[ST_READY_BIT]) else $error("bad blocked read");
   test_block_a: assert property (ram_test_req |-> !ready)
      else $error("ready in ram test");
   test_end_a: assert property (ram_test_req && ram_test_done |-> ##[1:3] !ram_test_req)
      else $error("test request stuck");
   sck_half_a: assert property ($rose(eeprom_serial_clock) |->
      eeprom_serial_clock [*4] ##1 !eeprom_serial_clock) else $error("bad sck half");
   sck_idle_a: assert property (eeprom_chip_select_n |-> !eeprom_serial_clock)
      else $error("sck high while idle");
   wr_hold_a: assert property (mem_wr_en && !mem_wr_ready && master_reset_n |=>
      mem_wr_en && $stable(mem_wr_addr) && $stable(mem_wr_data)) else $error("word lost");
   bus_block_a: assert property ((bus_a_transmit_inhibit && master_reset_n) [*6] |->
      bus_a_tx_block) else $error("inhibit not applied");
endmodule
bind rip_top rip_top_chk chk_i (.*);

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
   import rip_pkg::*;
   logic clk, reset_n, master_reset_n, rt_timetag_clock_in, monitor_timetag_clock_in;
   logic bus_a_transmit_inhibit, bus_b_transmit_inhibit, ram_test_disable, self_init_enable;
   logic self_init_short_range, terminal_address_parity_pin, eeprom_miso, rt_busy, mt_busy;
   logic ram_test_done, host_wr_en, host_rd_en, mem_wr_ready, eeprom_chip_select_n, ready;
   logic eeprom_serial_clock, eeprom_mosi, ram_test_req, host_rd_valid, mem_wr_en, activity;
   logic bus_a_tx_block, bus_b_tx_block, rt_soft_reset, mt_soft_reset, terminal_address_parity;
   logic [4:0] terminal_address_pins, terminal_address;
   logic [5:0] ta_m;
   logic [12:0] host_addr, mem_wr_addr, a_v;
   logic [15:0] host_wr_data, host_rd_data, mem_wr_data, rt_time_tag, mt_time_tag, cfg_m, rd_v;
   logic [15:0] mem_m [8192];
   logic [15:0] mem_rd_data, t0, t1;
   int error_cnt, samples_checked, cyc, nwr, stall, sck_n, n0;
   rip_top dut (.*);
   rip_eeprom ee (.cs_n(eeprom_chip_select_n), .sck(eeprom_serial_clock), .mosi(eeprom_mosi),
      .miso(eeprom_miso));
   assign mem_rd_data = mem_m[host_addr];
   always #25 clk = ~clk;
   always @(posedge eeprom_serial_clock) sck_n++;
   task automatic finish_test;
      $display("mismatches %0d of %0d checks", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic chk(string name, logic [23:0] seen, logic [23:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic idle;
      for (int i = 0; i < 99 && mem_wr_en; i++) @(negedge clk);
   endtask
   task automatic wr(logic [12:0] a, logic [15:0] d);
      idle;
      host_addr = a;
      host_wr_data = d;
      host_wr_en = 1;
      @(negedge clk) host_wr_en = 0;
   endtask
   task automatic rd(logic [12:0] a);
      host_addr = a;
      host_rd_en = 1;
      @(negedge clk) host_rd_en = 0;
      chk("rd_valid", host_rd_valid, 1);
      rd_v = host_rd_data;
   endtask
   task automatic mreset(logic td, logic se, logic sh);
      master_reset_n = 0;
      ram_test_disable = td;
      self_init_enable = se;
      self_init_short_range = sh;
      ta_m = 6'($urandom);
      {terminal_address_parity_pin, terminal_address_pins} = ta_m;
      repeat (6) @(negedge clk);
      master_reset_n = 1;
      repeat (8) @(negedge clk);
      // pins moved after release must not reach the latched address
      {terminal_address_parity_pin, terminal_address_pins} = ~ta_m;
   endtask
   // stall 4 refuses every word, stall 0 accepts all
   always @(negedge clk)
   begin
      mem_wr_ready <= ($urandom % 4) >= stall;
      cyc <= cyc + 1;
      if (cyc == 40000)
      begin
         error_cnt++;
         finish_test;
      end
   end
   always @(posedge clk)
      if (mem_wr_en && mem_wr_ready)
      begin
         mem_m[mem_wr_addr] <= mem_wr_data;
         nwr <= nwr + 1;
      end
   initial
   begin
      {clk, reset_n, master_reset_n, rt_timetag_clock_in, monitor_timetag_clock_in} = 0;
      {bus_a_transmit_inhibit, bus_b_transmit_inhibit, ram_test_disable, self_init_enable} = 0;
      {self_init_short_range, terminal_address_pins, terminal_address_parity_pin} = 0;
      {rt_busy, mt_busy, ram_test_done, host_wr_en, host_rd_en, host_addr, host_wr_data} = 0;
      mem_wr_ready = 0;
      void'($urandom(32'hDEE73A2F));
      repeat (6) @(negedge clk);
      reset_n = 1;
      mreset(0, 0, 1);
      chk("test_req", ram_test_req, 1);
      rd(13'h0123);
      chk("status", rd_v & 16'hF803, 16'h2000);
      wr(REG_CFG_ADDR, 16'h00F2);
      ram_test_done = 1;
      @(negedge clk) ram_test_done = 0;
      for (int i = 0; i < 99 && !ready; i++) @(negedge clk);
      chk("ready", ready, 1);
      chk("taddr", {terminal_address_parity, terminal_address}, ta_m);
      rd(REG_CFG_ADDR);
      chk("cfg_drop", rd_v & 16'h00F2, 0);
      $display("test 1 done");
      for (int i = 0; i < 8; i++)
      begin
         cfg_m = 16'($urandom) & 16'h0032;
         {bus_a_transmit_inhibit, bus_b_transmit_inhibit, rt_busy, mt_busy} = 4'($urandom);
         wr(REG_CFG_ADDR, cfg_m);
         repeat (5) @(negedge clk);
         chk("blk_a", bus_a_tx_block, bus_a_transmit_inhibit | cfg_m[CFG_INH_A_BIT]);
         chk("blk_b", bus_b_tx_block, bus_b_transmit_inhibit | cfg_m[CFG_INH_B_BIT]);
         chk("act", activity, rt_busy | (mt_busy & cfg_m[CFG_MON_ACT_BIT]));
         rd(REG_CFG_ADDR);
         chk("cfg", rd_v & 16'h00F2, cfg_m);
      end
      {bus_a_transmit_inhibit, bus_b_transmit_inhibit, rt_busy, mt_busy} = 0;
      $display("test 2 done");
      for (int i = 0; i < 2; i++)
      begin
         wr(REG_CFG_ADDR, i ? 16'h0080 : 16'h0040);
         t0 = rt_time_tag;
         t1 = mt_time_tag;
         repeat (40)
         begin
            repeat (4) @(negedge clk);
            rt_timetag_clock_in = ~rt_timetag_clock_in;
            monitor_timetag_clock_in = ~monitor_timetag_clock_in;
         end
         repeat (4) @(negedge clk);
         t0 = rt_time_tag - t0;
         t1 = mt_time_tag - t1;
         chk("ext_tt", i ? t1 : t0, 16'h0014);
         chk("int_tt", (i ? t0 : t1) inside {[7:9]}, 1);
      end
      wr(REG_STATUS_ADDR, 16'h0003);
      chk("srst", {rt_soft_reset, mt_soft_reset}, 2'h3);
      repeat (2) @(negedge clk);
      chk("srst_tt", {rt_time_tag < 3, mt_time_tag < 3}, 2'h3);
      $display("test 3 done");
      stall = 2;
      repeat (6)
      begin
         a_v = 13'($urandom_range(8191, 2));
         cfg_m = 16'($urandom);
         wr(a_v, cfg_m);
         repeat (2) @(negedge clk);
         idle;
         rd(a_v);
         chk("mem", rd_v, cfg_m);
      end
      $display("test 4 done");
      stall = 4;
      mreset(1, 1, 1);
      rd(13'h0005);
      chk("status", rd_v & 16'hF803, 16'h5800);
      repeat (1200) @(negedge clk);
      n0 = sck_n;
      repeat (100) @(negedge clk);
      chk("sck_halt", sck_n, n0);
      chk("hdr", ee.hdr_q, {EE_READ_CMD, EE_START_ADDR});
      n0 = nwr;
      stall = 0;
      for (int i = 0; i < 999 && nwr < n0 + 6; i++) @(negedge clk);
      for (int k = 2; k < 8; k++)
         chk("init_word", mem_m[k], 16'(k * 16'h0107 + 16'h3C5A));
      stall = 4;
      repeat (1000) @(negedge clk);
      mreset(1, 0, 1);
      stall = 0;
      rd(REG_STATUS_ADDR);
      chk("status", rd_v & 16'hF803, 16'h8000);
      chk("cs_idle", eeprom_chip_select_n, 1);
      $display("test 5 done");
      finish_test;
   end
endmodule
